// ### rtl/lec_if.sv
// event bundle passed from decoder top to the counter store
interface lec_ev_if #(parameter int AW = 3);
  logic          hit;       // an event lands this cycle
  logic [AW-1:0] slot;      // target tributary slot
  logic [3:0]    word;      // target counter word
  logic [2:0]    flags;     // flag bits to or in
  logic          clr;       // zero whole slot
  modport src (output hit, slot, word, flags, clr);
  modport dst (input hit, slot, word, flags, clr);
endinterface

// ### rtl/lec_pkg.sv
// Notes on behaviour
// - error counters eight bits, saturate at 255
// - statistics counters sixteen bits, saturate at 65535
// - count data sent, received, selection intervals
// - one set per established tributary slot
// - zero set on clear, establish, read-clear
// - sets live in per-tributary status slots
// - nak carries address and reason code
// - outbound error counter counts received naks
// - received nak reason sets outbound flags
// - header error sets inbound flag, counts
// - control station charges selected tributary
// - tributary records only own-address header errors
// - naks due set inbound data/reply flags
// - local reply counter counts rep sent
// - remote reply counter counts ack-to-rep sent
// - local buffer counter, flags on reasons 8/16
// - remote buffer counter, flags on reasons 8/16
// - retransmitted messages are not counted
// - out-of-sequence or errored receptions not counted
// - selections counted only by half-duplex/control
package lec_pkg;
  // ==========================================================
  // nak reason codes
  localparam logic [4:0] RSN_HDR   = 5'h01;
  localparam logic [4:0] RSN_DATA  = 5'h02;
  localparam logic [4:0] RSN_REP   = 5'h03;
  localparam logic [4:0] RSN_BUSY  = 5'h08;
  localparam logic [4:0] RSN_SMALL = 5'h10;
  // ==========================================================
  // slot word layout: word index within a tributary slot
  localparam logic [3:0] W_OUT_ERR  = 4'h0; // outbound errors + flags
  localparam logic [3:0] W_IN_ERR   = 4'h1; // inbound errors + flags
  localparam logic [3:0] W_LREP     = 4'h2; // local reply timeouts
  localparam logic [3:0] W_RREP     = 4'h3; // remote reply timeouts
  localparam logic [3:0] W_LBUF     = 4'h4; // local buffer errors + flags
  localparam logic [3:0] W_RBUF     = 4'h5; // remote buffer errors + flags
  localparam logic [3:0] W_TX       = 4'h6; // data messages sent
  localparam logic [3:0] W_RX       = 4'h7; // data messages received
  localparam logic [3:0] W_SEL      = 4'h8; // selection intervals
  localparam logic [3:0] W_CLEAR    = 4'hf; // write: clear slot
  // flag field position in error words
  localparam int FLAG_LSB = 8;
  localparam logic [7:0]  ERR_MAX  = 8'hff;
  localparam logic [15:0] STAT_MAX = 16'hffff;
  // station roles
  localparam logic [1:0] ROLE_P2P  = 2'h0;
  localparam logic [1:0] ROLE_CTRL = 2'h1;
  localparam logic [1:0] ROLE_TRIB = 2'h2;
endpackage

// ### rtl/lec_store.sv
// per-tributary counter slots held in a small array
module lec_store #(
  parameter int NT = 8,
  parameter int AW = 3
) (
  input  wire logic           ref_clk,
  input  wire logic           rst_b,
  lec_ev_if.dst               ev,
  input  wire logic [AW-1:0]  rd_slot,
  input  wire logic [3:0]     rd_word,
  output logic [15:0]         rd_val
);
  // ==========================================================
  // storage: 9 words per slot
  logic [15:0] mem_q [NT][9];

  // saturating step for error word: count low, flags high
  function automatic logic [15:0] bump_err(input logic [15:0] v, input logic [2:0] f);
    logic [7:0] c;
    c = (v[7:0] == lec_pkg::ERR_MAX) ? v[7:0] : v[7:0] + 8'h01;
    return {v[15:11], v[10:8] | f, c};
  endfunction

  function automatic logic [15:0] bump_stat(input logic [15:0] v);
    return (v == lec_pkg::STAT_MAX) ? v : v + 16'h0001;
  endfunction

  wire logic is_stat = ev.word >= lec_pkg::W_TX;

  // ==========================================================
  // update process
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      for (int i = 0; i < NT; i++)
        for (int j = 0; j < 9; j++)
          mem_q[i][j] <= 16'h0000;
    end else if (ev.clr) begin
      for (int j = 0; j < 9; j++)
        mem_q[ev.slot][j] <= 16'h0000;
    end else if (ev.hit && ev.word <= lec_pkg::W_SEL) begin
      mem_q[ev.slot][ev.word] <= is_stat ? bump_stat(mem_q[ev.slot][ev.word])
                                         : bump_err(mem_q[ev.slot][ev.word], ev.flags);
    end
  end

  // read mux, unmapped words read zero
  assign rd_val = (rd_word <= lec_pkg::W_SEL) ? mem_q[rd_slot][rd_word] : 16'h0000;
endmodule

// ### rtl/lec_top.sv
// link error statistics counters, one set per tributary
module lec_top #(
  parameter int NT = 8,
  parameter int AW = 3
) (
  input  wire logic          ref_clk,
  input  wire logic          rst_b,
  input  wire logic [1:0]    role,          // station role
  input  wire logic          half_duplex,   // half-duplex line
  input  wire logic [7:0]    own_addr,      // own station address
  input  wire logic [AW-1:0] sel_trib,      // currently selected tributary
  input  wire logic          nak_rx,        // nak received pulse
  input  wire logic          nak_tx_due,    // nak due to be sent pulse
  input  wire logic [4:0]    nak_reason,    // reason code
  input  wire logic [7:0]    msg_addr,      // address field of message
  input  wire logic [AW-1:0] msg_trib,      // tributary of message
  input  wire logic          hdr_err,       // header check error seen
  input  wire logic          rep_tx,        // rep poll sent
  input  wire logic          ack_rep_tx,    // ack to rep sent
  input  wire logic          data_tx,       // data message sent
  input  wire logic          data_retx,     // that send is a retransmission
  input  wire logic          data_rx,       // data message received
  input  wire logic          rx_bad,        // out of sequence or in error
  input  wire logic          sel_flag,      // sent with select flag
  input  wire logic          establish,     // establish command pulse
  input  wire logic [AW-1:0] est_trib,      // tributary to establish
  input  wire logic [7:0]    addr,          // register address
  input  wire logic [15:0]   wdata,
  input  wire logic          wr,
  input  wire logic          rd,
  output logic [15:0]        rdata
);
  // ==========================================================
  // register address: slot in [6:4] for AW = 3, word in [3:0]
  lec_ev_if #(.AW(AW)) ev ();
  logic [15:0] rd_val;
  logic [15:0] rdata_q;
  wire logic [AW-1:0] r_slot = addr[4 +: AW];
  wire logic [3:0]    r_word = addr[3:0];

  // point-to-point uses slot zero only
  wire logic p2p = role == lec_pkg::ROLE_P2P;
  wire logic [AW-1:0] tgt = p2p ? '0 : msg_trib;

  // header errors: control charges selected tributary; trib needs own address
  wire logic hdr_ok = (role != lec_pkg::ROLE_TRIB) || (msg_addr == own_addr);
  wire logic [AW-1:0] hdr_tgt = (role == lec_pkg::ROLE_CTRL) ? sel_trib : tgt;

  // software clear: write to clear word or read of it
  wire logic sw_clr = (wr || rd) && r_word == lec_pkg::W_CLEAR;
  wire logic sel_ok = half_duplex || role == lec_pkg::ROLE_CTRL;

  // ==========================================================
  // event priority select; one event per cycle, clears win
  always_comb begin
    ev.hit = 1'b0;
    ev.slot = tgt;
    ev.word = lec_pkg::W_OUT_ERR;
    ev.flags = 3'h0;
    ev.clr = 1'b0;
    if (establish) begin
      ev.clr = 1'b1; ev.slot = est_trib;
    end else if (sw_clr) begin
      ev.clr = 1'b1; ev.slot = r_slot;
    end else if (nak_rx) begin
      ev.hit = 1'b1;
      unique case (nak_reason)
        lec_pkg::RSN_HDR:   ev.flags = 3'h1;
        lec_pkg::RSN_DATA:  ev.flags = 3'h2;
        lec_pkg::RSN_REP:   ev.flags = 3'h4;
        lec_pkg::RSN_BUSY:  begin ev.word = lec_pkg::W_RBUF; ev.flags = 3'h1; end
        lec_pkg::RSN_SMALL: begin ev.word = lec_pkg::W_RBUF; ev.flags = 3'h2; end
        default:            ev.hit = 1'b0;
      endcase
    end else if (hdr_err && hdr_ok) begin
      ev.hit = 1'b1; ev.slot = hdr_tgt; ev.word = lec_pkg::W_IN_ERR; ev.flags = 3'h1;
    end else if (nak_tx_due) begin
      ev.hit = 1'b1;
      unique case (nak_reason)
        lec_pkg::RSN_DATA:  begin ev.word = lec_pkg::W_IN_ERR; ev.flags = 3'h2; end
        lec_pkg::RSN_REP:   begin ev.word = lec_pkg::W_IN_ERR; ev.flags = 3'h4; end
        lec_pkg::RSN_BUSY:  begin ev.word = lec_pkg::W_LBUF; ev.flags = 3'h1; end
        lec_pkg::RSN_SMALL: begin ev.word = lec_pkg::W_LBUF; ev.flags = 3'h2; end
        default:            ev.hit = 1'b0;
      endcase
    end else if (rep_tx) begin
      ev.hit = 1'b1; ev.word = lec_pkg::W_LREP;
    end else if (ack_rep_tx) begin
      ev.hit = 1'b1; ev.word = lec_pkg::W_RREP;
    end else if (data_tx && !data_retx) begin
      ev.hit = 1'b1; ev.word = lec_pkg::W_TX;
    end else if (data_rx && !rx_bad) begin
      ev.hit = 1'b1; ev.word = lec_pkg::W_RX;
    end else if (sel_flag && sel_ok) begin
      ev.hit = 1'b1; ev.slot = p2p ? '0 : sel_trib; ev.word = lec_pkg::W_SEL;
    end
  end

  lec_store #(.NT(NT), .AW(AW)) u_store (
    .ref_clk (ref_clk),
    .rst_b   (rst_b),
    .ev      (ev),
    .rd_slot (r_slot),
    .rd_word (r_word),
    .rd_val  (rd_val)
  );

  // ==========================================================
  // read data, one cycle after strobe
  always_ff @(posedge ref_clk) begin
    if (!rst_b) rdata_q <= 16'h0000;
    else if (rd) rdata_q <= rd_val;
    else rdata_q <= 16'h0000;
  end
  assign rdata = rdata_q;
endmodule

// ### tb/lec_remote.sv
// ==========================================================
// remote station: naks it sends us and naks we owe it
module lec_remote (
  input  wire logic       ref_clk,
  input  wire logic       go_rx,
  input  wire logic       go_tx,
  input  wire logic [4:0] rsn,
  output logic            nak_rx = 1'b0,
  output logic            nak_tx_due = 1'b0,
  output logic [4:0]      nak_reason = 5'h00
);
  // one pulse per nak; the code stands only beside it
  always @(posedge ref_clk) begin
    nak_rx <= go_rx;
    nak_tx_due <= go_tx;
    // outside a nak the field is junk, so flip it each cycle
    nak_reason <= (go_rx | go_tx) ? rsn : ~nak_reason;
  end
endmodule

// ### tb/lec_top_sva.sv
// ==========================================================
// port checks on the counter block
module lec_top_chk #(parameter int AW = 3) (
  input wire logic          ref_clk,
  input wire logic          rst_b,
  input wire logic          establish,
  input wire logic          nak_rx,
  input wire logic          nak_tx_due,
  input wire logic          hdr_err,
  input wire logic          rep_tx,
  input wire logic          ack_rep_tx,
  input wire logic          data_tx,
  input wire logic          data_retx,
  input wire logic          data_rx,
  input wire logic          rx_bad,
  input wire logic          sel_flag,
  input wire logic          wr,
  input wire logic          rd,
  input wire logic [AW-1:0] est_trib,
  input wire logic [7:0]    addr,
  input wire logic [15:0]   rdata
);
  // nothing but a read, which clears a slot at the clear word, that may move a counter this cycle
  wire quiet = !(establish | wr | nak_rx | nak_tx_due | hdr_err | rep_tx | ack_rep_tx |
    sel_flag | (data_tx & !data_retx) | (data_rx & !rx_bad));
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_b);
  property p_idle; !$past(rd) |-> rdata == 16'h0000; endproperty
  a_idle: assert property (p_idle) else $error("data without a read");
  property p_rclr; (rd && addr[3:0] == 4'hf) |=> rdata == 16'h0000; endproperty
  a_rclr: assert property (p_rclr) else $error("clear word not zero");
  property p_clr; (wr && addr[3:0] == 4'hf) ##1 (rd && quiet &&
    addr[7:4] == $past(addr[7:4])) |=> rdata == 16'h0000; endproperty
  a_clr: assert property (p_clr) else $error("slot not zero after clear");
  property p_est; establish ##1 (rd && quiet && addr[7:4] == 4'($past(est_trib)))
    |=> rdata == 16'h0000; endproperty
  a_est: assert property (p_est) else $error("slot not zero after establish");
  property p_hi; (rd && addr[3:0] < 4'h6) |=> rdata[15:11] == 5'h00; endproperty
  a_hi: assert property (p_hi) else $error("error word top bits set");
  property p_buf; (rd && addr[3:1] == 3'h2) |=> !rdata[10]; endproperty
  a_buf: assert property (p_buf) else $error("buffer word third flag");
  property p_flag; (rd && addr[3:0] < 4'h6) |=> (rdata[10:8] == 3'h0 || rdata[7:0] != 8'h00);
  endproperty
  a_flag: assert property (p_flag) else $error("flag with zero count");
  property p_hold; quiet ##1 (rd && quiet && addr[3:0] != 4'hf) ##1 (rd && quiet &&
    $stable(addr)) |=> $stable(rdata); endproperty
  a_hold: assert property (p_hold) else $error("count moved without event");
endmodule
bind lec_top lec_top_chk #(.AW(AW)) chk_u (.*);

// ### tb/lec_top_test.sv
`define CK(n, e, g) begin cmp_count++; if ((g) !== (e)) begin miscompares++; \
  $display("BAD %0s exp %h got %h", n, e, g); end end
// ==========================================================
// bench: pulses p = hdr, rep, ack, tx, rx, sel, establish
module lec_top_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk = 1'b0, rst_b = 1'b0, half_duplex = 1'b0, wr = 1'b0, rd = 1'b0, q = 1'b0;
  logic go_rx = 1'b0, go_tx = 1'b0, nak_rx, nak_tx_due;
  logic [1:0] role = 2'h1;
  logic [2:0] sel_trib = 3'h0, msg_trib = 3'h0;
  logic [4:0] rsn = 5'h00, nak_reason;
  logic [6:0] p = 7'h00;
  logic [7:0] own_addr = 8'h33, msg_addr = 8'h00, addr = 8'h00;
  logic [15:0] rdata;
  logic [4:0] cs[6] = '{5'h01, 5'h02, 5'h03, 5'h08, 5'h10, 5'h04};
  // selections land on the selected tributary, not on the message's slot
  logic [15:0] ex[7] = '{16'h2, 16'h1, 16'h0, 16'h0, 16'h2, 16'h1, 16'h0};
  int eb[10] = '{1, 1, 2, 3, 3, 3, 4, 4, 5, 5};
  int miscompares = 0, cmp_count = 0;
  lec_remote rem_u (.ref_clk(ref_clk), .go_rx(go_rx), .go_tx(go_tx), .rsn(rsn),
    .nak_rx(nak_rx), .nak_tx_due(nak_tx_due), .nak_reason(nak_reason));
  lec_top #(.NT(8), .AW(3)) dut_u (.ref_clk(ref_clk), .rst_b(rst_b), .role(role),
    .half_duplex(half_duplex), .own_addr(own_addr), .sel_trib(sel_trib), .nak_rx(nak_rx),
    .nak_tx_due(nak_tx_due), .nak_reason(nak_reason), .msg_addr(msg_addr),
    .msg_trib(msg_trib), .hdr_err(p[0]), .rep_tx(p[1]), .ack_rep_tx(p[2]), .data_tx(p[3]),
    .data_retx(q), .data_rx(p[4]), .rx_bad(q), .sel_flag(p[5]), .establish(p[6]),
    .est_trib(msg_trib), .addr(addr), .wdata(16'h0000), .wr(wr), .rd(rd), .rdata(rdata));
  // 250 MHz
  initial forever #2 ref_clk = ~ref_clk;
  // one event pulse, left up until the next driver call
  task automatic ev(input int b, input logic [2:0] t, input logic bad);
    @(posedge ref_clk);
    p <= 7'(1 << b);
    msg_trib <= t;
    q <= bad;
  endtask
  // nak over the line, received or owed
  task automatic nk(input logic rx, input logic [4:0] r, input logic [2:0] t);
    @(posedge ref_clk);
    p <= 7'h00;
    {go_rx, go_tx, rsn, msg_trib} <= {rx, !rx, r, t};
    @(posedge ref_clk);
    {go_rx, go_tx} <= 2'b00;
  endtask
  // two back-to-back reads of one word, both judged
  task automatic chk(input logic [7:0] a, input logic [15:0] e);
    @(posedge ref_clk);
    {rd, wr, p, addr} <= {1'b1, 1'b0, 7'h00, a};
    // first read taken at the next edge, judged mid-cycle
    @(posedge ref_clk);
    @(negedge ref_clk) `CK("rdata", e, rdata)
    // second read taken here; the strobe drops on this same edge
    @(posedge ref_clk);
    rd <= 1'b0;
    @(negedge ref_clk) `CK("rdata", e, rdata)
    // hand back on a rising edge so callers change levels there
    @(posedge ref_clk);
  endtask
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  // hang guard
  initial begin
    // well past the longest run, still under the cycle budget
    #380000;
    miscompares++;
    conclude();
  end
  initial begin
    repeat (10) @(posedge ref_clk);
    rst_b <= 1'b1;
    for (int i = 0; i < 6; i++) nk(1'b1, cs[i], 3'h1);
    chk(8'h10, 16'h0703);
    chk(8'h15, 16'h0302);
    for (int i = 1; i < 6; i++) nk(1'b0, cs[i], 3'h2);
    chk(8'h21, 16'h0602);
    chk(8'h24, 16'h0302);
    $display("nak test done");
    sel_trib <= 3'h2;
    ev(0, 3'h5, 1'b0);
    chk(8'h21, 16'h0703);
    {role, msg_addr} <= {2'h2, 8'h34};
    ev(0, 3'h2, 1'b0);
    chk(8'h21, 16'h0703);
    msg_addr <= 8'h33;
    ev(0, 3'h2, 1'b0);
    chk(8'h21, 16'h0704);
    role <= 2'h0;
    ev(0, 3'h6, 1'b0);
    chk(8'h01, 16'h0101);
    chk(8'h61, 16'h0000);
    $display("header test done");
    role <= 2'h1;
    for (int i = 0; i < 10; i++) ev(eb[i], 3'h3, i == 4 || i == 7);
    for (int i = 0; i < 7; i++) chk(8'h32 + 8'(i), ex[i]);
    chk(8'h28, 16'h0002);
    role <= 2'h0;
    ev(5, 3'h0, 1'b0);
    chk(8'h08, 16'h0000);
    half_duplex <= 1'b1;
    ev(5, 3'h0, 1'b0);
    chk(8'h08, 16'h0001);
    $display("count test done");
    role <= 2'h1;
    repeat (260) nk(1'b1, 5'h01, 3'h4);
    chk(8'h40, 16'h01ff);
    ev(3, 3'h5, 1'b0);
    repeat (65540) @(posedge ref_clk);
    chk(8'h56, 16'hffff);
    $display("saturation test done");
    ev(6, 3'h1, 1'b0);
    chk(8'h10, 16'h0000);
    chk(8'h15, 16'h0000);
    @(posedge ref_clk);
    {wr, addr} <= {1'b1, 8'h2f};
    chk(8'h21, 16'h0000);
    chk(8'h3f, 16'h0000);
    chk(8'h32, 16'h0000);
    rst_b <= 1'b0;
    repeat (2) @(posedge ref_clk);
    rst_b <= 1'b1;
    chk(8'h56, 16'h0000);
    $display("clear test done");
    conclude();
  end
endmodule
